// ==== cce_fifo.sv ====
`timescale 1ns/1ns

// Plain synchronous FIFO; DEPTH must be a power of two
module cce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Fill side
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  // Drain side
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_ptr_q[AW-1:0]];

  // Storage, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end
  end

  // Write pointer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
    end
  end

  // Read pointer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
    end
  end

endmodule // cce_fifo

// ==== cce_expander.sv ====
`timescale 1ns/1ns

// ****************************************
// Shared constants
// ****************************************
package cce_pkg;
  // Widths and buffer depth
  localparam int CODE_W = 8;
  localparam int LEVEL_W = 14;
  localparam int FIFO_DEPTH = 16;

  // Word layout: sign, chord, step
  localparam int SIGN_BIT = 7;
  localparam int CHORD_MSB = 6;
  localparam int CHORD_LSB = 4;
  localparam int STEP_MSB = 3;
  localparam int STEP_LSB = 0;

  // Mu-law chord bias in half units (16 steps times two)
  localparam logic [LEVEL_W-1:0] MU_BIAS = 14'h0020;
  // A-law zero offset, one half unit
  localparam logic [LEVEL_W-1:0] ZERO_OFS = 14'h0001;

  // Values after reset: mu-law, decode, level zero
  localparam logic SYNC_RST = 1'b0;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 14'h0000;
endpackage

module cce_expander (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Mode pins, asynchronous
  input wire logic i_alaw_sel,
  input wire logic i_encode_sel,
  // Code word stream in
  input wire logic [cce_pkg::CODE_W-1:0] i_code,
  input wire logic i_code_valid,
  output logic o_code_ready,
  // Linear level stream out, half-unit steps
  output logic signed [cce_pkg::LEVEL_W-1:0] o_level,
  output logic o_level_valid,
  input wire logic i_level_ready
);
  import cce_pkg::*;

  // ****************************************
  // Data path summary
  // ****************************************
  // Words pass a sixteen-word buffer, then one register stage
  // Expansion is done as a word leaves the buffer
  // Mode pins act on the word leaving, not the word entering
  // Limitation: queued words take a mode change made after them
  // Levels are in half units, so every half-step is a whole count
  // Trade-off: one extra bit of width buys exact half-steps
  // A half-unit zero offset on the magnitude keeps the two A-law zeros apart
  // Mu-law zeros both give level zero in decode mode
  // Encode adds the chord's half-step, decode adds nothing
  // No software access; modes come only from the two pins

  // ****************************************
  // Expansion arithmetic
  // ****************************************
  // Result is in half units so the half-steps stay exact
  // Widest mu level plus half-step still fits the width
  function automatic logic signed [LEVEL_W-1:0] cce_expand(
    input logic [CODE_W-1:0] code,
    input logic alaw,
    input logic enc
  );
    logic [2:0] chord;
    logic [3:0] step;
    logic [LEVEL_W-1:0] base;
    logic [LEVEL_W-1:0] mag;
    logic [LEVEL_W-1:0] half;
    chord = code[CHORD_MSB:CHORD_LSB];
    step = code[STEP_MSB:STEP_LSB];
    // sixteen steps above an implied one
    // The implied one marks where each chord starts
    base = {{(LEVEL_W-5){1'b0}}, 1'b1, step};
    if (!alaw) begin
      // Bias takes off chord 0's implied one, so zero is zero
      // Half-step doubles with the chord, as the step does
      // step doubles each chord
      mag = (base << (4'(chord) + 4'd1)) - MU_BIAS;
      half = 14'h0001 << chord;
    end else if (chord == 3'd0) begin
      // Chord 0 has no implied one and starts at zero
      // chord 0 same step as chord 1
      mag = {{(LEVEL_W-5){1'b0}}, step, 1'b0};
      half = 14'h0001;
    end else begin
      // Chord c starts at sixteen shifted up by c
      // doubling from chord 2 upward
      mag = base << chord;
      half = 14'h0001 << (chord - 3'd1);
    end
    // zero offset keeps both zeros apart
    if (alaw) begin
      mag = mag + ZERO_OFS;
    end
    if (enc) begin
      mag = mag + half;
    end
    // Negation is exact: no magnitude reaches the signed limit
    // sign mirrors the magnitude
    if (code[SIGN_BIT]) begin
      return -$signed(mag);
    end
    return $signed(mag);
  endfunction

  // ****************************************
  // Mode pin synchronisers
  // ****************************************
  // Pins are not timed to i_clk, so they pass three stages
  // Cost: a pin change reaches the data path four edges late
  // Reset picks mu-law decode until the pins are adopted
  logic [2:0] alaw_sync_q;
  logic [2:0] enc_sync_q;
  logic alaw_q;
  logic enc_q;

  // Three stages; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alaw_sync_q <= {3{SYNC_RST}};
      enc_sync_q <= {3{SYNC_RST}};
    end else begin
      alaw_sync_q <= {alaw_sync_q[1:0], i_alaw_sel};
      enc_sync_q <= {enc_sync_q[1:0], i_encode_sel};
    end
  end

  // Accept a new mode only when stages two and three agree
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alaw_q <= SYNC_RST;
      enc_q <= SYNC_RST;
    end else begin
      if (alaw_sync_q[1] == alaw_sync_q[2]) begin
        alaw_q <= alaw_sync_q[2];
      end
      if (enc_sync_q[1] == enc_sync_q[2]) begin
        enc_q <= enc_sync_q[2];
      end
    end
  end

  // ****************************************
  // Code buffer
  // ****************************************
  // Sixteen words ride out a stalled sink without a loss
  // Ready falls only when the buffer itself is full
  // Drain side ready comes from the output stage below
  logic [CODE_W-1:0] fifo_code;
  logic fifo_valid;
  logic fifo_ready;
  logic level_valid_q;
  logic signed [LEVEL_W-1:0] level_q;
  logic signed [LEVEL_W-1:0] level_d;

  // Output stage takes a word when empty or being drained
  assign fifo_ready = !level_valid_q || i_level_ready;

  cce_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_in_data(i_code),
    .i_in_valid(i_code_valid),
    .o_in_ready(o_code_ready),
    .o_out_data(fifo_code),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready)
  );

  // ****************************************
  // Output stage
  // ****************************************
  // Next level from the word at the head of the buffer
  always_comb begin
    level_d = cce_expand(fifo_code, alaw_q, enc_q);
  end

  // Mode is sampled when the word leaves the buffer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_q <= LEVEL_RST;
    end else if (fifo_valid && fifo_ready) begin
      level_q <= level_d; // One stage keeps the output path short
    end
  end

  // Valid holds until the sink takes the level
  // It drops only when the level was taken and none waits
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_valid_q <= 1'b0;
    end else if (fifo_ready) begin
      level_valid_q <= fifo_valid;
    end
  end

  // Both ports come straight from registers
  assign o_level = level_q;
  assign o_level_valid = level_valid_q;

endmodule // cce_expander

// ==== cce_monitor.sv ====
`timescale 1ns/1ns
// ****
// Port checks
// ****
module cce_monitor (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_alaw_sel,
  input wire logic i_encode_sel,
  input wire logic [cce_pkg::CODE_W-1:0] i_code,
  input wire logic i_code_valid,
  input wire logic o_code_ready,
  input wire logic signed [cce_pkg::LEVEL_W-1:0] o_level,
  input wire logic o_level_valid,
  input wire logic i_level_ready
);
  import cce_pkg::*;
  logic [5:0] fill_q;
  logic [2:0] age_q;
  logic [1:0] pins_q;
  logic new_q;
  logic ok;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Words inside, buffer plus output stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fill_q <= 6'h00;
    end else begin
      fill_q <= fill_q + 6'(i_code_valid & o_code_ready)
        - 6'(o_level_valid & i_level_ready);
    end
  end
  // Pin age; the synchroniser hides fresh changes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pins_q <= 2'h0;
      age_q <= 3'h0;
      new_q <= 1'b0;
    end else begin
      pins_q <= {i_alaw_sel, i_encode_sel};
      new_q <= !o_level_valid || i_level_ready;
      if (pins_q != {i_alaw_sel, i_encode_sel}) begin
        age_q <= 3'h0;
      end else if (age_q != 3'h7) begin
        age_q <= age_q + 3'h1;
      end
    end
  end
  // Level freshly loaded under settled pins
  assign ok = o_level_valid && new_q && age_q == 3'h7;
  AST_HOLD: assert property (o_level_valid && !i_level_ready |=>
    o_level_valid && $stable(o_level)) else $error("level not held");
  AST_READY: assert property (fill_q < 6'h10 |-> o_code_ready)
    else $error("refused with room left");
  AST_GHOST: assert property (o_level_valid |-> fill_q != 6'h00)
    else $error("level without a word");
  AST_DRAIN: assert property (fill_q != 6'h00 && i_level_ready
    |-> ##[0:3] o_level_valid) else $error("word not delivered");
  AST_MU_EVEN: assert property (ok && !i_alaw_sel && !i_encode_sel
    |-> !o_level[0]) else $error("mu decode level odd");
  AST_A_ODD: assert property (ok && i_alaw_sel && !i_encode_sel
    |-> o_level[0]) else $error("a decode level even");
  AST_MU_TOP: assert property (ok && !i_alaw_sel && !i_encode_sel
    |-> o_level <= 7904 && o_level >= -7904) else $error("mu range");
  AST_A_TOP: assert property (ok && i_alaw_sel
    |-> o_level <= 4033 && o_level >= -4033) else $error("a range");
  // A word taken into an empty block shows its sign two edges on
  AST_SIGN: assert property (fill_q == 6'h00 && i_code_valid
    && o_code_ready |-> ##2 (o_level_valid && (o_level == 0 ||
    (o_level < 0) == $past(i_code[SIGN_BIT], 2))))
    else $error("level sign differs from word sign");
endmodule // cce_monitor

// ==== cce_source.sv ====
`timescale 1ns/1ns
// ****
// Code word source
// ****
module cce_source (
  // Stream out
  input wire logic i_clk,
  output logic [7:0] o_code,
  output logic o_valid,
  input wire logic i_ready
);
  logic late = 1'b0;
  initial o_code = 8'h00;
  initial o_valid = 1'b0;
  // sign, chord, step
  // Word held whole until taken; ready is settled at the falling edge
  task automatic send(logic [7:0] c);
    bit r;
    int n;
    o_code = c;
    o_valid = 1'b1;
    for (n = 0; n < 100; n++) begin
      r = i_ready;
      @(negedge i_clk);
      if (r) break;
    end
    if (n == 100) late = 1'b1;
  endtask
  // Released lines show the inverse of the last word
  task automatic stop;
    o_valid = 1'b0;
    o_code = ~o_code;
  endtask
endmodule // cce_source

// ==== companding_code_expander_test.sv ====
`timescale 1ns/1ns
// ****
// Sweeps of every code in each mode
// ****
module companding_code_expander_test;
  import cce_pkg::*;
  logic clk = 0, rst_n = 0, alaw = 0, enc = 0, rdy = 0, cv, cr, lv;
  logic [7:0] code;
  logic signed [LEVEL_W-1:0] lvl;
  logic signed [LEVEL_W-1:0] got[$];
  int errors = 0, compares = 0, stall = 0;
  always #2 clk = ~clk;
  cce_source src (.i_clk(clk), .o_code(code), .o_valid(cv), .i_ready(cr));
  cce_expander dut (.i_clk(clk), .i_arst_n(rst_n), .i_alaw_sel(alaw),
    .i_encode_sel(enc), .i_code(code), .i_code_valid(cv),
    .o_code_ready(cr), .o_level(lvl), .o_level_valid(lv),
    .i_level_ready(rdy));
  // Sink; a stall lets the buffer fill until it refuses
  always @(negedge clk) begin
    rdy = (stall == 0);
    if (stall > 0) stall = stall - 1;
    if (lv && rdy) got.push_back(lvl);
  end
  function automatic logic [LEVEL_W-1:0] want(logic [7:0] c, logic a, e);
    int s, ch, m;
    s = c[3:0];
    ch = c[6:4];
    if (!a) m = ((16 + s) << (ch + 1)) - 32 + (e ? 1 << ch : 0);
    else if (ch == 0) m = 2 * s + 1 + e;
    else m = ((16 + s) << ch) + 1 + (e ? 1 << (ch - 1) : 0);
    return c[7] ? LEVEL_W'(-m) : LEVEL_W'(m);
  endfunction
  task automatic chk(string what, logic [LEVEL_W-1:0] exp, seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_bit(string what, logic exp, seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Pins settle first, then all 256 words go back to back
  task automatic sweep(logic a, e, int st);
    int n;
    alaw = a;
    enc = e;
    got.delete();
    repeat (8) @(negedge clk);
    stall = st;
    for (int i = 0; i < 256; i++) src.send(8'(i));
    src.stop();
    for (n = 0; n < 2000 && got.size() < 256; n++) @(negedge clk);
    if (n == 2000 || src.late) errors++;
    if (n == 2000 || src.late) summarize();
    for (int i = 0; i < 256; i++) begin
      chk("level", want(8'(i), a, e), got[i]);
    end
    $display("sweep alaw %0b encode %0b done", a, e);
  endtask
  task automatic mu_decode_stalled;
    sweep(1'b0, 1'b0, 60);
  endtask
  task automatic alaw_decode;
    sweep(1'b1, 1'b0, 0);
  endtask
  task automatic mu_encode;
    sweep(1'b0, 1'b1, 0);
  endtask
  task automatic alaw_encode;
    sweep(1'b1, 1'b1, 0);
  endtask
  // Reset with words in flight must empty both stages
  task automatic reset_midway;
    stall = 40;
    for (int i = 0; i < 10; i++) src.send(8'(i));
    src.stop();
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk_bit("ready in reset", 1'b1, cr);
    chk_bit("valid in reset", 1'b0, lv);
    chk("level in reset", LEVEL_RST, lvl);
    rst_n = 1'b1;
    stall = 0;
    repeat (2) begin
      @(negedge clk);
      chk_bit("valid after reset", 1'b0, lv);
      chk_bit("ready after reset", 1'b1, cr);
    end
    $display("reset midway done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    mu_decode_stalled();
    reset_midway();
    alaw_decode();
    mu_encode();
    alaw_encode();
    summarize();
  end
endmodule // companding_code_expander_test
bind cce_expander cce_monitor mon (.i_clk, .i_arst_n, .i_alaw_sel,
  .i_encode_sel, .i_code, .i_code_valid, .o_code_ready, .o_level,
  .o_level_valid, .i_level_ready);
